// >>> design/flash_rst_pkg.sv
/*
 * Shared constants for the flash reset and power-up controller: opcodes,
 * state and operation encodings, timing figures and their cycle counts.
 * Assumes a 20 MHz core clock; the recovery counts below derive from that rate.
 */
// Contract
// [RULE1] Restart pin low for at least the pulse width triggers a full reset.
// [RULE2] After a reset cycle the device sits in standby, ready for commands.
// [RULE3] Reset returns latch, busy and volatile lock bits to power-on defaults.
// [RULE4] Restart during program or erase aborts it; written data may be lost.
// [RULE5] Serial data output stays disabled while the restart pin is low.
// [RULE6] Reset during decoding needs 20 us recovery before a new command.
// [RULE7] Reset during status write needs 20 us recovery before reselection.
// [RULE8] Host waits per interrupted operation: 20 us read/program, 12 ms erase.
// [RULE9] Software reset needs enable 66h first, then reset 99h.
// [RULE10] Power-up lands in ordinary standby, never deep power-down.
// [RULE11] Power-up clears the write latch flag.
// [RULE12] Host keeps chip select inactive through power-up settle and power-down.
// [RULE13] Below write-inhibit threshold logic is held reset, commands ignored.
// [RULE14] Write-type commands blocked until write-unlock delay after threshold.
// [RULE15] Reads accepted after supply minimum plus settle, before write unlock.
// [RULE16] Falling below threshold at power-down disables all operations.
`default_nettype none
package flash_rst_pkg;
    localparam int CORE_CLK_HZ = 20_000_000;
    localparam int TIMER_W = 20;

    // Recovery figures in their own units
    localparam int REC_DECODE_US = 20;
    localparam int REC_READ_US = 20;
    localparam int REC_PROG_US = 20;
    localparam int REC_STATUS_US = 20;
    localparam int REC_ERASE_MS = 12;

    // Longest times: round down
    localparam int REC_DECODE_CYC = REC_DECODE_US * (CORE_CLK_HZ / 1_000_000);
    localparam int REC_READ_CYC = REC_READ_US * (CORE_CLK_HZ / 1_000_000);
    localparam int REC_PROG_CYC = REC_PROG_US * (CORE_CLK_HZ / 1_000_000);
    localparam int REC_STATUS_CYC = REC_STATUS_US * (CORE_CLK_HZ / 1_000_000);
    localparam int REC_ERASE_CYC = REC_ERASE_MS * (CORE_CLK_HZ / 1_000);

    // Figures the timing table leaves blank; plain defaults
    localparam int RESTART_PW_CYC = 200;
    localparam int SETTLE_CYC = 2000;
    localparam int UNLOCK_CYC = 20000;
    localparam int PROG_TIME_CYC = 200;
    localparam int ERASE_TIME_CYC = 4000;
    localparam int STATUS_TIME_CYC = 200;
    localparam int LOCK_BITS = 8;

    localparam logic [7:0] CMD_WRITE_LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_STATUS_REG_WRITE_CMD = 8'h01;
    localparam logic [7:0] CMD_PP = 8'h02;
    localparam logic [7:0] CMD_4PP = 8'h38;
    localparam logic [7:0] CMD_SE = 8'h20;
    localparam logic [7:0] CMD_BE32K = 8'h52;
    localparam logic [7:0] CMD_BE = 8'hd8;
    localparam logic [7:0] CMD_CE = 8'h60;
    localparam logic [7:0] CMD_CE_ALT = 8'hc7;
    localparam logic [7:0] CMD_SECURITY_REG_WRITE_CMD = 8'h2f;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] CMD_DEEP_PD = 8'hb9;
    localparam logic [7:0] CMD_RELEASE_PD = 8'hab;
    localparam logic [7:0] CMD_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] CMD_RST_EN = 8'h66;
    localparam logic [7:0] CMD_RST = 8'h99;

    localparam logic [7:0] OPCODE_RESET = 8'h00;
    localparam logic [3:0] BITCNT_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_POWER_OFF = 3'b000,
        ST_SETTLE = 3'b001,
        ST_READY = 3'b011,
        ST_BUSY = 3'b010,
        ST_RESET_HOLD = 3'b110,
        ST_RECOVER = 3'b111
    } ctl_state_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_STATUS = 2'b11
    } op_kind_t;
endpackage
`default_nettype wire

// >>> design/level_sync3.sv
/*
 * Three-flop synchroniser for a group of independent levels.
 * Assumes each input is a slow level; a change is taken once the
 * second and third flops agree, giving a filtered, registered output.
 */
`default_nettype none
module level_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    generate
        for (genvar b = 0; b < WIDTH; b++) begin : g_bit
            always_comb begin
                level_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : level_r[b];
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
            level_r <= RESET_VAL;
        end else begin
            meta_r <= i_async;
            s2_r <= meta_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign o_level = level_r;
endmodule // level_sync3
`default_nettype wire

// >>> design/cmd_shift_rx.sv
/*
 * Serial-clock side opcode receiver. Shifts the first eight bits of each
 * chip-select frame and flips a toggle when an opcode is complete.
 * Assumes the host clocks data in on rising edges while chip select is low;
 * the serial clock may stop between frames, so frame state is cleared by
 * chip select itself rather than by any clock edge.
 */
`default_nettype none
module cmd_shift_rx
    import flash_rst_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic [7:0] o_opcode,
    output logic o_cmd_toggle
);
    logic frame_rst_n;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] opcode_r;
    logic [7:0] opcode_nxt;
    logic toggle_r;
    logic toggle_nxt;

    assign frame_rst_n = i_rst_n & ~i_cs_n;

    always_comb begin
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        if (bitcnt_r < 4'h8) begin
            bitcnt_nxt = bitcnt_r + 4'h1;
            shift_nxt = {shift_r[6:0], i_si};
        end
    end

    // Opcode stays put until the next complete opcode, long past the crossing
    always_comb begin
        opcode_nxt = opcode_r;
        toggle_nxt = toggle_r;
        if (bitcnt_r == 4'h7) begin
            opcode_nxt = {shift_r[6:0], i_si};
            toggle_nxt = ~toggle_r;
        end
    end

    always_ff @(posedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bitcnt_r <= BITCNT_RESET;
            shift_r <= OPCODE_RESET;
        end else begin
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
        end
    end

    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            opcode_r <= OPCODE_RESET;
            toggle_r <= 1'b0;
        end else begin
            opcode_r <= opcode_nxt;
            toggle_r <= toggle_nxt;
        end
    end

    assign o_opcode = opcode_r;
    assign o_cmd_toggle = toggle_r;
endmodule // cmd_shift_rx
`default_nettype wire

// >>> design/flash_reset_powerup_control.sv
/*
 * Reset and power-up sequencer of a serial flash: restart pin filter,
 * software reset pair, recovery timing, power-on lockout and write unlock.
 * Assumes supply comparators and the restart pin arrive asynchronously and
 * the host serial clock is a separate, possibly stopped, clock domain.
 */
`default_nettype none
module flash_reset_powerup_control
    import flash_rst_pkg::*;
#(
    parameter int RESTART_PW_CYCLES = RESTART_PW_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int UNLOCK_CYCLES = UNLOCK_CYC,
    parameter int ERASE_REC_CYCLES = REC_ERASE_CYC,
    parameter int PROG_CYCLES = PROG_TIME_CYC,
    parameter int ERASE_CYCLES = ERASE_TIME_CYC,
    parameter int STATUS_CYCLES = STATUS_TIME_CYC,
    parameter int NUM_LOCKS = LOCK_BITS
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_restart_n,
    input wire logic i_supply_inhibit_ok,
    input wire logic i_supply_min_ok,
    output logic o_so_enable,
    output logic o_cmd_ready,
    output logic o_standby,
    output logic o_write_latch_flag,
    output logic o_write_busy_flag,
    output logic o_deep_powerdown,
    output logic [NUM_LOCKS-1:0] o_block_lock,
    output logic [1:0] o_op_kind,
    output logic o_op_start,
    output logic o_op_abort,
    output logic o_read_start
);
    localparam int TMAX = 2 ** TIMER_W;

    // Timers are TIMER_W bits wide; longer figures would wrap
    if (RESTART_PW_CYCLES < 1 || RESTART_PW_CYCLES >= TMAX ||
        SETTLE_CYCLES < 1 || SETTLE_CYCLES >= TMAX ||
        UNLOCK_CYCLES < 1 || UNLOCK_CYCLES >= TMAX ||
        ERASE_REC_CYCLES < 1 || ERASE_REC_CYCLES >= TMAX ||
        PROG_CYCLES < 1 || PROG_CYCLES >= TMAX ||
        ERASE_CYCLES < 1 || ERASE_CYCLES >= TMAX ||
        STATUS_CYCLES < 1 || STATUS_CYCLES >= TMAX || NUM_LOCKS < 1) begin : g_param_check
        $error("flash_reset_powerup_control: parameter out of range");
    end

    logic [7:0] rx_opcode;
    logic rx_toggle;
    logic [2:0] pins_s;
    logic restart_ok;
    logic inhibit_ok;
    logic min_ok;
    logic tog_meta_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic cmd_evt;

    cmd_shift_rx u_rx (
        .i_sclk(i_sclk),
        .i_rst_n(i_rst_n),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_opcode(rx_opcode),
        .o_cmd_toggle(rx_toggle)
    );

    level_sync3 #(
        .WIDTH(3),
        .RESET_VAL(3'h1)
    ) u_pin_sync (
        .i_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_supply_min_ok, i_supply_inhibit_ok, i_restart_n}),
        .o_level(pins_s)
    );

    assign restart_ok = pins_s[0];
    assign inhibit_ok = pins_s[1];
    assign min_ok = pins_s[2];

    // Toggle crossing; opcode changes on the same edge as the toggle and is held stable long after it lands
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tog_meta_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_meta_r <= rx_toggle;
            tog_s2_r <= tog_meta_r;
            tog_s3_r <= tog_s2_r;
        end
    end
    assign cmd_evt = tog_s2_r ^ tog_s3_r;

    ctl_state_t state_r, state_nxt;
    op_kind_t kind_r, kind_nxt;
    logic [TIMER_W-1:0] timer_r, timer_nxt;
    logic [TIMER_W-1:0] lowcnt_r, lowcnt_nxt;
    logic [TIMER_W-1:0] unlock_r, unlock_nxt;
    logic [TIMER_W-1:0] rec_r, rec_nxt;
    logic latch_r, latch_nxt;
    logic busy_r, busy_nxt;
    logic deep_r, deep_nxt;
    logic armed_r, armed_nxt;
    logic [NUM_LOCKS-1:0] lock_r, lock_nxt;
    logic start_r, start_nxt;
    logic abort_r, abort_nxt;
    logic read_r, read_nxt;
    logic hold_hit;
    logic unlock_done;
    logic sw_reset;
    logic is_write_cmd;

    // [RULE1] Restart pulse filter
    assign hold_hit = !restart_ok && (lowcnt_r == TIMER_W'(RESTART_PW_CYCLES - 1));
    // [RULE14] Write unlock delay
    assign unlock_done = (unlock_r == TIMER_W'(UNLOCK_CYCLES));
    // [RULE9] Reset only after enable
    assign sw_reset = cmd_evt && armed_r && (rx_opcode == CMD_RST);
    assign is_write_cmd = (rx_opcode == CMD_STATUS_REG_WRITE_CMD) || (rx_opcode == CMD_PP) ||
        (rx_opcode == CMD_4PP) || (rx_opcode == CMD_SE) || (rx_opcode == CMD_BE32K) ||
        (rx_opcode == CMD_BE) || (rx_opcode == CMD_CE) || (rx_opcode == CMD_CE_ALT) ||
        (rx_opcode == CMD_SECURITY_REG_WRITE_CMD);

    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        timer_nxt = timer_r;
        rec_nxt = rec_r;
        latch_nxt = latch_r;
        busy_nxt = busy_r;
        deep_nxt = deep_r;
        armed_nxt = armed_r;
        lock_nxt = lock_r;
        start_nxt = 1'b0;
        abort_nxt = 1'b0;
        read_nxt = 1'b0;
        lowcnt_nxt = restart_ok ? '0 :
            (hold_hit ? lowcnt_r : lowcnt_r + TIMER_W'(1));
        unlock_nxt = !inhibit_ok ? '0 : (unlock_done ? unlock_r : unlock_r + TIMER_W'(1));
        if (cmd_evt) begin
            armed_nxt = (rx_opcode == CMD_RST_EN);
        end
        if (!inhibit_ok) begin
            // [RULE13] Held in reset below threshold
            // [RULE16] Power-down disables everything
            state_nxt = ST_POWER_OFF;
            kind_nxt = OP_NONE;
            timer_nxt = '0;
            // [RULE11] Latch cleared at power-up
            latch_nxt = 1'b0;
            busy_nxt = 1'b0;
            // [RULE10] Standby, not deep power-down
            deep_nxt = 1'b0;
            armed_nxt = 1'b0;
            lock_nxt = '1;
        end else if (hold_hit || (sw_reset && (state_r == ST_READY || state_r == ST_BUSY))) begin
            // [RULE4] Abort running operation
            abort_nxt = (state_r == ST_BUSY);
            // [RULE8] Recovery chosen by interrupted work
            unique case (kind_r)
                OP_ERASE: rec_nxt = TIMER_W'(ERASE_REC_CYCLES - 1);
                OP_PROG: rec_nxt = TIMER_W'(REC_PROG_CYC - 1);
                // [RULE7] Status write recovery
                OP_STATUS: rec_nxt = TIMER_W'(REC_STATUS_CYC - 1);
                // [RULE6] Decode recovery
                OP_NONE: rec_nxt = TIMER_W'(REC_DECODE_CYC - 1);
            endcase
            if (state_r == ST_RESET_HOLD || state_r == ST_RECOVER) begin
                rec_nxt = rec_r;
            end
            // [RULE3] Volatile bits to defaults
            latch_nxt = 1'b0;
            busy_nxt = 1'b0;
            deep_nxt = 1'b0;
            armed_nxt = 1'b0;
            lock_nxt = '1;
            kind_nxt = OP_NONE;
            state_nxt = hold_hit ? ST_RESET_HOLD : ST_RECOVER;
            timer_nxt = hold_hit ? timer_r : rec_nxt;
        end else begin
            unique case (state_r)
                ST_POWER_OFF: begin
                    if (min_ok) begin
                        state_nxt = ST_SETTLE;
                        timer_nxt = TIMER_W'(SETTLE_CYCLES - 1);
                    end
                end
                ST_SETTLE: begin
                    if (!min_ok) begin
                        state_nxt = ST_POWER_OFF;
                    end else if (timer_r == '0) begin
                        state_nxt = ST_READY;
                    end else begin
                        timer_nxt = timer_r - TIMER_W'(1);
                    end
                end
                ST_READY: begin
                    if (cmd_evt && deep_r) begin
                        deep_nxt = (rx_opcode != CMD_RELEASE_PD);
                    end else if (cmd_evt) begin
                        // [RULE15] Reads before write unlock
                        if (rx_opcode == CMD_READ || rx_opcode == CMD_FAST_READ) begin
                            read_nxt = 1'b1;
                        end
                        if (rx_opcode == CMD_DEEP_PD) begin
                            deep_nxt = 1'b1;
                        end
                        if (rx_opcode == CMD_WRDI) begin
                            latch_nxt = 1'b0;
                        end
                        // [RULE14] Writes locked out until unlocked
                        if (rx_opcode == CMD_WRITE_LATCH_SET_CMD && unlock_done) begin
                            latch_nxt = 1'b1;
                        end
                        if (rx_opcode == CMD_UNLOCK_ALL && unlock_done && latch_r) begin
                            lock_nxt = '0;
                            latch_nxt = 1'b0;
                        end
                        if (is_write_cmd && unlock_done && latch_r) begin
                            state_nxt = ST_BUSY;
                            busy_nxt = 1'b1;
                            start_nxt = 1'b1;
                            if (rx_opcode == CMD_STATUS_REG_WRITE_CMD) begin
                                kind_nxt = OP_STATUS;
                                timer_nxt = TIMER_W'(STATUS_CYCLES - 1);
                            end else if (rx_opcode == CMD_PP || rx_opcode == CMD_4PP ||
                                         rx_opcode == CMD_SECURITY_REG_WRITE_CMD) begin
                                kind_nxt = OP_PROG;
                                timer_nxt = TIMER_W'(PROG_CYCLES - 1);
                            end else begin
                                kind_nxt = OP_ERASE;
                                timer_nxt = TIMER_W'(ERASE_CYCLES - 1);
                            end
                        end
                    end
                end
                ST_BUSY: begin
                    if (timer_r == '0) begin
                        state_nxt = ST_READY;
                        busy_nxt = 1'b0;
                        latch_nxt = 1'b0;
                        kind_nxt = OP_NONE;
                    end else begin
                        timer_nxt = timer_r - TIMER_W'(1);
                    end
                end
                ST_RESET_HOLD: begin
                    if (restart_ok) begin
                        state_nxt = ST_RECOVER;
                        timer_nxt = rec_r;
                    end
                end
                ST_RECOVER: begin
                    // [RULE2] Back to standby when recovered
                    if (timer_r == '0) begin
                        state_nxt = ST_READY;
                    end else begin
                        timer_nxt = timer_r - TIMER_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_POWER_OFF;
            kind_r <= OP_NONE;
            timer_r <= '0;
            rec_r <= '0;
            lowcnt_r <= '0;
            unlock_r <= '0;
            latch_r <= 1'b0;
            busy_r <= 1'b0;
            deep_r <= 1'b0;
            armed_r <= 1'b0;
            lock_r <= '1;
            start_r <= 1'b0;
            abort_r <= 1'b0;
            read_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            timer_r <= timer_nxt;
            rec_r <= rec_nxt;
            lowcnt_r <= lowcnt_nxt;
            unlock_r <= unlock_nxt;
            latch_r <= latch_nxt;
            busy_r <= busy_nxt;
            deep_r <= deep_nxt;
            armed_r <= armed_nxt;
            lock_r <= lock_nxt;
            start_r <= start_nxt;
            abort_r <= abort_nxt;
            read_r <= read_nxt;
        end
    end

    // [RULE5] Output disabled in reset
    assign o_so_enable = (state_r == ST_READY || state_r == ST_BUSY) && restart_ok;
    assign o_cmd_ready = (state_r == ST_READY);
    assign o_standby = (state_r == ST_READY) && !deep_r;
    assign o_write_latch_flag = latch_r;
    assign o_write_busy_flag = busy_r;
    assign o_deep_powerdown = deep_r;
    assign o_block_lock = lock_r;
    assign o_op_kind = kind_r;
    assign o_op_start = start_r;
    assign o_op_abort = abort_r;
    assign o_read_start = read_r;

    so_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
        (state_r == ST_RESET_HOLD || !restart_ok) |-> !o_so_enable)
        else $error("serial output enabled during restart");
    reset_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
        (state_r == ST_RESET_HOLD) |-> (!latch_r && !busy_r && (lock_r == '1)))
        else $error("volatile bits not defaulted in reset");
    pulse_width_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
        $rose(!restart_ok) && inhibit_ok ##1 (!restart_ok) [*3] |-> state_r != ST_RESET_HOLD)
        else $error("restart taken before pulse width");
    abort_op_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE4]
        (state_r == ST_BUSY && hold_hit && inhibit_ok) |=> (o_op_abort && !busy_r))
        else $error("operation not aborted by restart");
    recover_len_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE6]
        (state_r == ST_READY && sw_reset && inhibit_ok && !hold_hit)
        |=> (state_r == ST_RECOVER && timer_r == TIMER_W'(REC_DECODE_CYC - 1)))
        else $error("decode recovery length wrong");
    recover_done_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE2]
        (state_r == ST_RECOVER && timer_r == '0 && inhibit_ok && !hold_hit)
        |=> (o_standby && o_cmd_ready))
        else $error("no standby after recovery");
    sw_arm_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE9]
        (cmd_evt && rx_opcode == CMD_RST && !armed_r && state_r == ST_READY && !hold_hit)
        |=> state_r != ST_RECOVER)
        else $error("reset honoured without enable");
    power_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE13]
        !inhibit_ok |=> (state_r == ST_POWER_OFF && !latch_r && !deep_r && !o_read_start))
        else $error("logic active below inhibit threshold");
    write_block_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE14]
        (cmd_evt && !unlock_done && (is_write_cmd || rx_opcode == CMD_WRITE_LATCH_SET_CMD))
        |=> (!o_op_start && o_write_latch_flag == $past(o_write_latch_flag)))
        else $error("write command passed before unlock");
    read_early_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE15]
        (cmd_evt && rx_opcode == CMD_READ && state_r == ST_READY && !deep_r &&
         inhibit_ok && !hold_hit) |=> o_read_start)
        else $error("read refused after settle");
    erase_rec_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE8]
        (state_r == ST_BUSY && kind_r == OP_ERASE && hold_hit && inhibit_ok)
        |=> rec_r == TIMER_W'(ERASE_REC_CYCLES - 1))
        else $error("erase recovery length wrong");
endmodule // flash_reset_powerup_control
`default_nettype wire

// >>> sim/host_link_model.sv
/* Host serial controller model: one opcode per chip-select frame.
   Assumes the bench calls send from its own process. */
`default_nettype none
module host_link_model (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
    end
    task automatic send(input logic [7:0] op);
        #17 o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            o_si = op[i];
            #62.5 o_sclk = 1'b1;
            #62.5 o_sclk = 1'b0;
        end
        #62.5 o_cs_n = 1'b1;
        // Released line must not look held
        o_si = ~op[0];
        #1000;
    endtask
endmodule // host_link_model
`default_nettype wire

// >>> sim/flash_reset_powerup_control_tb.sv
/* Bench for the reset and power-up sequencer.
   Assumes shortened counts; the host model drives the link. */
`default_nettype none
module flash_reset_powerup_control_tb;
    import flash_rst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, restart_n = 1, inh_ok = 0, min_ok = 0;
    wire sclk, cs_n, si, so_en, rdy, stby, write_latch_flag, write_busy_flag, dpd, st, ab, rd;
    wire [1:0] kind;
    wire [7:0] lock;
    logic [1:0] seen_kind;
    logic [7:0] op;
    logic [31:0] seed = 32'h0000_fc70;
    int miscompares = 0, n_checks = 0, n_rd = 0, n_ab = 0, n_st = 0;
    always #25 core_clk = ~core_clk;
    host_link_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));
    // Unlock and program at real length, so reads run before unlock
    flash_reset_powerup_control #(.RESTART_PW_CYCLES(4), .SETTLE_CYCLES(8),
        .ERASE_REC_CYCLES(50), .ERASE_CYCLES(5),
        .STATUS_CYCLES(5)) dut_u (.i_core_clk(core_clk),
        .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .i_restart_n(restart_n), .i_supply_inhibit_ok(inh_ok),
        .i_supply_min_ok(min_ok), .o_so_enable(so_en), .o_cmd_ready(rdy),
        .o_standby(stby), .o_write_latch_flag(write_latch_flag), .o_write_busy_flag(write_busy_flag),
        .o_deep_powerdown(dpd), .o_block_lock(lock), .o_op_kind(kind),
        .o_op_start(st), .o_op_abort(ab), .o_read_start(rd));
    always @(posedge core_clk) begin
        if (rd === 1'b1) n_rd++;
        if (ab === 1'b1) n_ab++;
        if (st === 1'b1) n_st++;
        if (write_busy_flag === 1'b1) seen_kind <= kind;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] exp_kind(input logic [7:0] o);
        return (o == CMD_STATUS_REG_WRITE_CMD) ? 2'h3 : 2'h2;
    endfunction
    function automatic logic [7:0] pick_op(input logic [2:0] s);
        case (s)
            3'h0, 3'h6: return CMD_STATUS_REG_WRITE_CMD;
            3'h2: return CMD_BE32K;
            3'h3: return CMD_BE;
            3'h4: return CMD_CE;
            3'h5: return CMD_CE_ALT;
            default: return CMD_SE;
        endcase
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready(input int n);
        for (int i = 0; i < n && rdy !== 1'b1; i++) begin
            @(posedge core_clk);
            #5;
        end
    endtask
    // Ends one edge later, so bench drives stay edge aligned
    task automatic cmd(input logic [7:0] o);
        host_u.send(o);
        @(posedge core_clk);
        #5;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #3_000_000 miscompares++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge core_clk);
        #5 rst_n = 1;
        cmd(CMD_WRITE_LATCH_SET_CMD);
        check(rdy, 0);
        inh_ok = 1;
        min_ok = 1;
        wait_ready(100);
        check({stby, dpd, write_latch_flag}, 3'b100);
        cmd(CMD_READ);
        check(n_rd, 1);
        cmd(CMD_FAST_READ);
        check(n_rd, 2);
        cmd(CMD_WRITE_LATCH_SET_CMD);
        check(write_latch_flag, 0);
        repeat (UNLOCK_CYC) @(posedge core_clk);
        #5;
        cmd(CMD_DEEP_PD);
        check({stby, dpd}, 2'b01);
        cmd(CMD_RELEASE_PD);
        check({stby, dpd}, 2'b10);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            op = pick_op(seed[2:0]);
            cmd(CMD_WRITE_LATCH_SET_CMD);
            check(write_latch_flag, 1);
            cmd(op);
            check({seen_kind, write_latch_flag, write_busy_flag}, {exp_kind(op), 2'b00});
        end
        cmd(CMD_WRITE_LATCH_SET_CMD);
        cmd(CMD_UNLOCK_ALL);
        check(lock, 8'h00);
        restart_n = 0;
        repeat (1 + seed[1]) @(posedge core_clk);
        #5 restart_n = 1;
        repeat (8) @(posedge core_clk);
        #5;
        check(rdy, 1);
        cmd(CMD_WRITE_LATCH_SET_CMD);
        cmd(CMD_PP);
        check(write_busy_flag, 1);
        check(n_st, 7);
        restart_n = 0;
        repeat (10) @(posedge core_clk);
        #5;
        check({so_en, write_busy_flag, write_latch_flag, n_ab[3:0]}, 7'h01);
        check(lock, 8'hff);
        restart_n = 1;
        repeat (300) @(posedge core_clk);
        #5;
        check(rdy, 0);
        wait_ready(200);
        check({rdy, stby}, 2'b11);
        cmd(CMD_RST);
        check(rdy, 1);
        cmd(CMD_RST_EN);
        cmd(CMD_RST);
        check(rdy, 0);
        wait_ready(600);
        check(rdy, 1);
        inh_ok = 0;
        repeat (8) @(posedge core_clk);
        #5;
        cmd(CMD_WRITE_LATCH_SET_CMD);
        check({stby, write_latch_flag}, 2'b00);
        wrap_up();
    end
endmodule // flash_reset_powerup_control_tb
`default_nettype wire
